/* File: bank_map_pkg.sv */
/*
 bank_map_pkg: constants shared by the code bank mapper.
 Assumes nothing of its surroundings.
*/
package bank_map_pkg;
	// ----------------------------------------
	// special-function register map
	// ----------------------------------------
	localparam logic [7:0] bank_select_addr = 8'hb1;
	localparam logic [7:0] store_control_addr = 8'h8f;
	localparam logic [7:0] bank_select_reset = 8'h11;
	localparam logic [7:0] store_control_reset = 8'h00;
	localparam int const_field_lo = 4;
	localparam int fetch_field_lo = 0;
	localparam int write_enable_bit = 0;
	localparam logic [7:0] bank_select_rw_mask = 8'h33;
	// ----------------------------------------
	// address space
	// ----------------------------------------
	localparam logic [7:0] sfr_base = 8'h80;
	localparam logic [16:0] reserved_base = 17'h1fc00;
	localparam logic [7:0] opcode_alias_nop = 8'ha5;
	localparam logic [7:0] opcode_nop = 8'h00;
	localparam int data_ram_bytes = 256;
	// ----------------------------------------
	// branch target kinds
	// ----------------------------------------
	typedef enum logic [1:0] {
		branch_relative,
		branch_absolute,
		branch_long
	} branch_kind_t;
endpackage

/* File: code_bank_mapper.sv */
/*
 code_bank_mapper: banked program store mapping, bank select and store control
 registers, operand address decode, branch targets and opcode alias.
 Assumes a core that gives one-cycle sfr write strobes and reads sfr data
 combinationally from a registered copy, all on mclk.
*/
`timescale 1ns/1ps

module code_bank_mapper import bank_map_pkg::*; #(
	parameter bit large_variant = 1'b1
) (
	input wire logic mclk, // system clock
	input wire logic arst_n, // async reset
	input wire logic clk_en, // freezes all state when low
	input wire logic [15:0] code_addr, // core code address
	input wire logic code_req, // code access strobe
	input wire logic code_is_fetch, // 1 fetch, 0 constant access
	input wire logic code_write, // external-move write to code
	input wire logic [15:0] fetch_pc, // address of running instruction
	input wire logic [7:0] sfr_addr, // direct operand address
	input wire logic sfr_write, // direct write strobe
	input wire logic sfr_read, // direct read strobe
	input wire logic [7:0] sfr_wdata, // direct write data
	input wire logic indirect, // access is indirect
	input wire logic [7:0] opcode_in, // opcode from fetch
	input wire logic [15:0] next_pc, // first byte of next instruction
	input wire logic [1:0] branch_kind, // branch_kind_t
	input wire logic [15:0] branch_operand, // rel, addr11 or addr16
	output logic [16:0] flash_addr, // linear flash address
	output logic flash_read, // flash read strobe
	output logic flash_write, // flash write strobe
	output logic [7:0] sfr_rdata, // sfr read data
	output logic ram_sel, // access hits data ram, direct below 0x80 or any indirect
	output logic sfr_sel, // direct access hits sfr
	output logic [7:0] opcode_out, // opcode after alias
	output logic [15:0] branch_target, // computed target
	output logic [7:0] bank_select_q, // bank select register
	output logic store_write_enable // write enable bit
);
	typedef struct packed {
		logic [7:0] bank_select;
		logic [7:0] store_control;
		logic [16:0] flash_addr;
		logic flash_read;
		logic flash_write;
		logic [7:0] sfr_rdata;
		logic ram_sel;
		logic sfr_sel;
		logic [7:0] opcode_out;
		logic [15:0] branch_target;
	} state_t;

	state_t st;
	state_t next_st;
	logic [1:0] bank;
	logic [1:0] fetch_bank;
	logic [1:0] const_bank;
	logic in_bank_zero;
	logic [15:0] rel_ext;

	assign fetch_bank = st.bank_select[fetch_field_lo +: 2];
	assign const_bank = st.bank_select[const_field_lo +: 2];
	assign rel_ext = {{8{branch_operand[7]}}, branch_operand[7:0]};
	// running code sits in bank zero when low half, or upper half with fetch field 00
	assign in_bank_zero = !fetch_pc[15] || fetch_bank == 2'b00;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		bank = code_is_fetch ? fetch_bank : const_bank;
		// ---- code address mapping ----
		if (!large_variant) begin
			next_st.flash_addr = {1'b0, code_addr};
		end else if (!code_addr[15]) begin
			next_st.flash_addr = {2'b00, code_addr[14:0]};
		end else begin
			next_st.flash_addr = {bank, code_addr[14:0]};
		end
		next_st.flash_read = code_req && !code_write;
		next_st.flash_write = code_req && code_write
			&& st.store_control[write_enable_bit];
		// ---- direct operand decode ----
		next_st.ram_sel = (sfr_read || sfr_write) && (indirect || sfr_addr < sfr_base);
		next_st.sfr_sel = (sfr_read || sfr_write) && !indirect && sfr_addr >= sfr_base;
		next_st.sfr_rdata = 8'h00;
		if (sfr_read && !indirect && sfr_addr == bank_select_addr) begin
			next_st.sfr_rdata = st.bank_select & bank_select_rw_mask;
		end else if (sfr_read && !indirect && sfr_addr == store_control_addr) begin
			next_st.sfr_rdata = st.store_control;
		end
		// ---- register writes, fetch field from bank zero only ----
		if (sfr_write && !indirect && sfr_addr == bank_select_addr) begin
			next_st.bank_select[const_field_lo +: 2] = sfr_wdata[const_field_lo +: 2];
			if (in_bank_zero) begin
				next_st.bank_select[fetch_field_lo +: 2] = sfr_wdata[fetch_field_lo +: 2];
			end
		end
		if (sfr_write && !indirect && sfr_addr == store_control_addr) begin
			next_st.store_control = sfr_wdata;
		end
		// ---- opcode alias ----
		next_st.opcode_out = (opcode_in == opcode_alias_nop) ? opcode_nop : opcode_in;
		// ---- branch targets ----
		unique case (branch_kind_t'(branch_kind))
			branch_relative: next_st.branch_target = next_pc + rel_ext;
			branch_absolute: next_st.branch_target =
				{next_pc[15:11], branch_operand[10:0]};
			branch_long: next_st.branch_target = branch_operand;
			default: next_st.branch_target = next_pc;
		endcase
	end

	// freeze on clk_en low; reset loads the register constants, all else zero
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '{bank_select: bank_select_reset, store_control: store_control_reset,
				default: '0};
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign flash_addr = st.flash_addr;
	assign flash_read = st.flash_read;
	assign flash_write = st.flash_write;
	assign sfr_rdata = st.sfr_rdata;
	assign ram_sel = st.ram_sel;
	assign sfr_sel = st.sfr_sel;
	assign opcode_out = st.opcode_out;
	assign branch_target = st.branch_target;
	assign bank_select_q = st.bank_select;
	assign store_write_enable = st.store_control[write_enable_bit];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_low_half_bank: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && large_variant && code_req && !code_addr[15] |=> flash_addr[16:15] == 2'b00)
		else $error("low half not bank zero");
	a_fetch_bank_map: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && large_variant && code_req && code_is_fetch && code_addr[15]
		|=> flash_addr[16:15] == $past(fetch_bank))
		else $error("fetch bank wrong");
	a_const_bank_map: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && large_variant && code_req && !code_is_fetch && code_addr[15]
		|=> flash_addr[16:15] == $past(const_bank))
		else $error("constant bank wrong");
	a_offset_kept: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && code_req |=> flash_addr[14:0] == $past(code_addr[14:0]))
		else $error("bank offset altered");
	a_fetch_guard: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && !in_bank_zero |=> fetch_bank == $past(fetch_bank))
		else $error("fetch field changed outside bank zero");
	a_reserved_zero: assert property (@(posedge mclk) disable iff (!arst_n)
		bank_select_q[7:6] == 2'b00 && sfr_rdata[7:6] == 2'b00)
		else $error("reserved bits nonzero");
	a_write_protect: assert property (@(posedge mclk) disable iff (!arst_n)
		flash_write |-> $past(store_write_enable) && $past(code_write))
		else $error("unprotected flash write");
	a_direct_split: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && sfr_read && !indirect |=> sfr_sel == $past(sfr_addr[7]) && ram_sel != sfr_sel)
		else $error("direct decode wrong");
	a_alias_nop: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && opcode_in == opcode_alias_nop |=> opcode_out == opcode_nop)
		else $error("alias opcode not nop");
	a_abs_page: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && branch_kind == 2'd1 |=> branch_target[15:11] == $past(next_pc[15:11]))
		else $error("absolute target left page");
	a_rel_target: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && branch_kind == 2'd0 |=> branch_target == $past(next_pc) + $past(rel_ext))
		else $error("relative target wrong");
	// a write attempt without the enable bit must leave the store untouched
	a_read_only: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && code_req && code_write && !store_write_enable |=> !flash_write)
		else $error("flash write without enable");
	a_read_strobe: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en |=> flash_read == ($past(code_req) && !$past(code_write)))
		else $error("flash read strobe wrong");
	// flat variant ignores both bank fields
	a_flat_map: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && !large_variant && code_req |=> flash_addr == {1'b0, $past(code_addr)})
		else $error("flat address altered");
	a_const_zero: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && large_variant && code_req && !code_is_fetch && code_addr[15]
		&& const_bank == 2'b00 |=> flash_addr[16:15] == 2'b00)
		else $error("constant code 00 not bank zero");
	// constant field always taken, fetch field only from bank zero
	a_const_write: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && sfr_write && !indirect && sfr_addr == bank_select_addr
		|=> const_bank == $past(sfr_wdata[5:4]))
		else $error("constant field write lost");
	a_fetch_write: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && sfr_write && !indirect && sfr_addr == bank_select_addr && in_bank_zero
		|=> fetch_bank == $past(sfr_wdata[1:0]))
		else $error("fetch field write lost");
	a_long_target: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && branch_kind == 2'd2 |=> branch_target == $past(branch_operand))
		else $error("long target wrong");
	a_abs_low: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && branch_kind == 2'd1 |=> branch_target[10:0] == $past(branch_operand[10:0]))
		else $error("absolute target low bits wrong");
	// indirect accesses above 0x7f land in the upper ram, never the sfr space
	a_indirect_ram: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && (sfr_read || sfr_write) && indirect |=> ram_sel && !sfr_sel)
		else $error("indirect access left ram");
	a_sel_idle: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && !sfr_read && !sfr_write |=> !ram_sel && !sfr_sel)
		else $error("select without access");
endmodule

/* File: core_model.sv */
/*
 core_model: program counter of the core beside the mapper.
 Assumes the bench loads a new counter value through load and load_pc.
*/
`timescale 1ns/1ps
module core_model (
	input wire logic mclk, // system clock
	input wire logic arst_n, // async reset
	input wire logic load, // take new counter value
	input wire logic [15:0] load_pc, // value to take
	output logic [15:0] fetch_pc, // running instruction
	output logic [15:0] next_pc // two-byte instruction assumed
);
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			fetch_pc <= 16'h0000;
		else if (load)
			fetch_pc <= load_pc;
	end
	assign next_pc = fetch_pc + 16'h0002;
endmodule

/* File: tb.sv */
/*
 tb: random and corner checks of code_bank_mapper.
 Assumes the design's latency of one enabled edge on every output.
*/
`timescale 1ns/1ps
module tb import bank_map_pkg::*;;
	logic mclk = 0, arst_n = 0, clk_en = 1, code_req = 0, code_is_fetch = 0, code_write = 0;
	logic sfr_write = 0, sfr_read = 0, indirect = 0, load = 0;
	logic [15:0] code_addr = 0, load_pc = 0, fetch_pc, next_pc, branch_operand = 0, branch_target;
	logic [7:0] sfr_addr = 0, sfr_wdata = 0, opcode_in = 0, sfr_rdata, opcode_out, bank_select_q;
	logic [1:0] branch_kind = 0;
	logic [16:0] flash_addr, flat_addr;
	logic flash_read, flash_write, ram_sel, sfr_sel, store_write_enable;
	logic [15:0] r;
	int n_errors = 0, checks_done = 0, cycles = 0;
	always #20 mclk = ~mclk;
	core_model core_u (.mclk, .arst_n, .load, .load_pc, .fetch_pc, .next_pc);
	code_bank_mapper #(.large_variant(1'b1)) dut_u (.mclk, .arst_n, .clk_en, .code_addr, .code_req,
		.code_is_fetch, .code_write, .fetch_pc, .sfr_addr, .sfr_write, .sfr_read, .sfr_wdata,
		.indirect, .opcode_in, .next_pc, .branch_kind, .branch_operand, .flash_addr, .flash_read,
		.flash_write, .sfr_rdata, .ram_sel, .sfr_sel, .opcode_out, .branch_target, .bank_select_q,
		.store_write_enable);
	code_bank_mapper #(.large_variant(1'b0)) flat_u (.mclk, .arst_n, .clk_en, .code_addr, .code_req,
		.code_is_fetch, .code_write, .fetch_pc, .sfr_addr, .sfr_write, .sfr_read, .sfr_wdata,
		.indirect, .opcode_in, .next_pc, .branch_kind, .branch_operand, .flash_addr(flat_addr),
		.flash_read(), .flash_write(), .sfr_rdata(), .ram_sel(), .sfr_sel(), .opcode_out(),
		.branch_target(), .bank_select_q(), .store_write_enable());
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [16:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick;
		@(posedge mclk);
		#1;
	endtask
	task automatic sfr_wr(input logic [7:0] a, d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_write = 1;
		tick;
		sfr_write = 0;
	endtask
	task automatic set_pc(input logic [15:0] p);
		load_pc = p;
		load = 1;
		tick;
		load = 0;
	endtask
	function automatic logic [15:0] exp_tgt(input logic [1:0] k, input logic [15:0] n, op);
		case (k)
			2'd0: return n + {{8{op[7]}}, op[7:0]};
			2'd1: return {n[15:11], op[10:0]};
			2'd2: return op;
			default: return n;
		endcase
	endfunction
	task automatic results;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			results;
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'ha043));
		repeat (6) @(posedge mclk);
		#1 arst_n = 1;
		chk("bank_select", bank_select_q, 8'h11);
		sfr_wr(8'hb1, 8'hff);
		chk("bank_select", bank_select_q, bank_select_rw_mask);
		set_pc(16'h9000);
		sfr_wr(8'hb1, 8'h02);
		chk("bank_select", bank_select_q, 8'h03);
		set_pc(16'h0000);
		for (int b = 0; b < 4; b++) begin
			sfr_wr(8'hb1, {2'b00, 2'(3 - b), 2'b00, 2'(b)});
			for (int k = 0; k < 8; k++) begin
				r = 16'($urandom) & 16'hfbff;
				code_addr = r;
				code_is_fetch = k[0];
				code_req = 1;
				tick;
				chk("flash_addr", flash_addr, r[15] ? {k[0] ? 2'(b) : 2'(3 - b), r[14:0]} : {1'b0, r});
				chk("flash_read", flash_read, 1'b1);
				chk("flat_addr", flat_addr, {1'b0, r});
			end
		end
		code_write = 1;
		tick;
		chk("flash_write", flash_write, 1'b0);
		chk("store_we", store_write_enable, 1'b0);
		sfr_wr(8'h8f, 8'h01);
		tick;
		chk("flash_write", flash_write, 1'b1);
		chk("store_we", store_write_enable, 1'b1);
		code_write = 0;
		code_req = 0;
		sfr_addr = 8'hb1;
		sfr_read = 1;
		tick;
		chk("sfr_rdata", sfr_rdata, 8'h03);
		sfr_addr = 8'h8f;
		tick;
		chk("sfr_rdata", sfr_rdata, 8'h01);
		clk_en = 0;
		sfr_wr(8'hb1, 8'h00);
		chk("bank_select", bank_select_q, 8'h03);
		clk_en = 1;
		set_pc(16'h07fe);
		for (int k = 0; k < 40; k++) begin
			r = 16'($urandom);
			sfr_addr = r[7:0];
			indirect = r[8];
			opcode_in = k < 2 ? opcode_alias_nop : r[15:8];
			branch_kind = 2'(k % 4);
			branch_operand = k == 0 ? 16'h0080 : 16'($urandom);
			tick;
			chk("ram_sel", ram_sel, 1'(indirect | ~sfr_addr[7]));
			chk("sfr_sel", sfr_sel, 1'(~indirect & sfr_addr[7]));
			chk("opcode", opcode_out, opcode_in == opcode_alias_nop ? opcode_nop : opcode_in);
			chk("target", branch_target, exp_tgt(branch_kind, next_pc, branch_operand));
		end
		results;
	end
endmodule
